// ===== common/smhlc_pkg.sv
package smhlc_pkg;
  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TICK_HZ = 2;
  localparam int unsigned TICK_CYC = CLK_HZ / TICK_HZ;
  localparam int unsigned SAMPLE_TIME_NS = 122_000;
  localparam int unsigned SAMPLE_CYC = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PRESC_W = 24;
  localparam int unsigned SAMPLE_W = 12;
  // ==========================================================================
  // Register map
  localparam logic [11:0] CTRL_INDEX = 12'h00fa;
  localparam logic [11:0] CTRL_ADDR = 12'(CTRL_INDEX * 4);
  localparam logic [11:0] IRQ_STAT_ADDR = 12'h0000;
  localparam logic [11:0] IRQ_CLR_ADDR = 12'h0004;
  localparam logic [11:0] IRQ_EN_ADDR = 12'h0008;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam int unsigned MODE_SEL_BIT = 3;
  localparam int unsigned LOW_RESULT_BIT = 1;
  localparam int unsigned DETECT_EN_BIT = 0;
  localparam int unsigned EV_DONE_BIT = 0;
  localparam int unsigned EV_LOW_BIT = 1;
  localparam int unsigned EV_AUTO_BIT = 2;
  // ==========================================================================
  // Types
  typedef struct packed {
    logic heavy_load_mode_select;
    logic zero;
    logic supply_low_result;
    logic supply_detect_enable;
  } smhlc_ctrl_t;

  typedef struct packed {
    logic write;
    logic [11:0] addr;
  } smhlc_aphase_t;

  typedef enum logic {
    SMHLC_IDLE,
    SMHLC_SAMPLE
  } smhlc_state_t;
endpackage : smhlc_pkg

// ===== core/smhlc_top.sv
`timescale 1ns/1ps
`default_nettype none
module smhlc_top
  import smhlc_pkg::*;
#(
  parameter bit LOW_VOLTAGE_VARIANT = 1'b1,
  parameter int unsigned PRESC_CYC = TICK_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Analog monitor
  input wire logic supply_low_raw,
  output logic supply_monitor_enable,
  // Power control
  output logic heavy_load_active,
  output logic lcd_doubled_supply_select,
  // Interrupt
  output logic irq
);

  // ==========================================================================
  // Decode
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
    addr_hit = (a[11:2] == off[11:2]);
  endfunction : addr_hit

  // ==========================================================================
  // Bus slave
  smhlc_aphase_t aph_ff;
  logic aph_valid_ff;
  logic hreadyout_ff;
  logic hresp_ff;
  logic [31:0] hrdata_ff;
  logic take;
  logic wr_ctrl;
  logic wr_clr;
  logic wr_en;
  smhlc_ctrl_t ctrl_ff;
  logic [2:0] irq_stat_ff;
  logic [2:0] irq_en_ff;
  logic irq_ff;

  // Only whole-word transfers are taken; a narrower one is ignored rather than half-applied
  assign take = hsel & hready & htrans[1] & (hsize == 3'h2);
  assign wr_ctrl = aph_valid_ff & aph_ff.write & addr_hit(aph_ff.addr, CTRL_ADDR);
  assign wr_clr = aph_valid_ff & aph_ff.write & addr_hit(aph_ff.addr, IRQ_CLR_ADDR);
  assign wr_en = aph_valid_ff & aph_ff.write & addr_hit(aph_ff.addr, IRQ_EN_ADDR);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      aph_ff <= '0;
      aph_valid_ff <= 1'b0;
    end else begin
      aph_valid_ff <= take;
      if (take) begin
        aph_ff <= '{write: hwrite, addr: haddr};
      end
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hreadyout_ff <= 1'b0;
      hresp_ff <= 1'b0;
    end else begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  // Read data is captured in the address phase; unmapped addresses read zero
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      if (addr_hit(haddr, CTRL_ADDR)) begin
        hrdata_ff <= {28'h000_0000, ctrl_ff.heavy_load_mode_select, 1'b0,
                      ctrl_ff.supply_low_result, ctrl_ff.supply_detect_enable};
      end else if (addr_hit(haddr, IRQ_STAT_ADDR)) begin
        hrdata_ff <= {29'h0000_0000, irq_stat_ff};
      end else if (addr_hit(haddr, IRQ_EN_ADDR)) begin
        hrdata_ff <= {29'h0000_0000, irq_en_ff};
      end else begin
        hrdata_ff <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================================
  // Comparator input synchroniser
  logic sync1_ff;
  logic sync2_ff;
  logic sync3_ff;
  logic cmp_low_ff;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
    end else begin
      sync1_ff <= supply_low_raw;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // A level counts only once two stages agree, so one late stage cannot glitch a latched result
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cmp_low_ff <= 1'b0;
    end else if (sync2_ff == sync3_ff) begin
      cmp_low_ff <= sync3_ff;
    end
  end

  // ==========================================================================
  // 2 Hz prescaler
  logic [PRESC_W-1:0] presc_ff;
  logic tick;

  assign tick = (presc_ff == PRESC_W'(PRESC_CYC - 1));

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      presc_ff <= '0;
    end else if (tick) begin
      presc_ff <= '0;
    end else begin
      presc_ff <= presc_ff + PRESC_W'(1);
    end
  end

  // ==========================================================================
  // Automatic sampling
  smhlc_state_t state_ff;
  logic [SAMPLE_W-1:0] samp_cnt_ff;
  logic auto_hl_ff;
  logic heavy;
  logic samp_done;
  logic oneshot_done;
  logic latch_now;

  assign heavy = ctrl_ff.heavy_load_mode_select | auto_hl_ff;
  assign samp_done = (state_ff == SMHLC_SAMPLE) && (samp_cnt_ff == '0);
  assign oneshot_done = wr_ctrl & ctrl_ff.supply_detect_enable & ~hwdata[DETECT_EN_BIT];
  assign latch_now = samp_done | oneshot_done;

  // A sample already running finishes even if the mode is left meanwhile
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= SMHLC_IDLE;
      samp_cnt_ff <= '0;
    end else begin
      unique case (state_ff)
        SMHLC_IDLE: begin
          if (heavy && tick) begin
            state_ff <= SMHLC_SAMPLE;
            samp_cnt_ff <= SAMPLE_W'(SAMPLE_CYC - 1);
          end
        end
        SMHLC_SAMPLE: begin
          if (samp_cnt_ff == '0) begin
            state_ff <= SMHLC_IDLE;
          end else begin
            samp_cnt_ff <= samp_cnt_ff - SAMPLE_W'(1);
          end
        end
      endcase
    end
  end

  // Only the low-voltage variants switch the mode on their own
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      auto_hl_ff <= 1'b0;
    end else if (LOW_VOLTAGE_VARIANT && latch_now) begin
      auto_hl_ff <= cmp_low_ff;
    end
  end

  // ==========================================================================
  // Control register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= smhlc_ctrl_t'(CTRL_RESET);
    end else begin
      if (wr_ctrl) begin
        ctrl_ff.heavy_load_mode_select <= hwdata[MODE_SEL_BIT];
        ctrl_ff.supply_detect_enable <= hwdata[DETECT_EN_BIT];
      end
      ctrl_ff.zero <= 1'b0;
      if (latch_now) begin
        ctrl_ff.supply_low_result <= cmp_low_ff;
      end
    end
  end

  // ==========================================================================
  // Interrupts
  logic [2:0] events;

  assign events[EV_DONE_BIT] = latch_now;
  assign events[EV_LOW_BIT] = latch_now & cmp_low_ff;
  assign events[EV_AUTO_BIT] = LOW_VOLTAGE_VARIANT & latch_now & cmp_low_ff & ~auto_hl_ff;

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_ff <= IRQ_RESET;
    end else if (wr_clr) begin
      irq_stat_ff <= (irq_stat_ff & ~hwdata[2:0]) | events;
    end else begin
      irq_stat_ff <= irq_stat_ff | events;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_en_ff <= IRQ_RESET;
    end else if (wr_en) begin
      irq_en_ff <= hwdata[2:0];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_stat_ff & irq_en_ff);
    end
  end

  // ==========================================================================
  // Power control outputs
  logic mon_en_ff;
  logic heavy_ff;
  logic dbl_sel_ff;

  // Software detection during heavy-load mode is not blocked; the caller avoids it
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mon_en_ff <= 1'b0;
    end else begin
      mon_en_ff <= ctrl_ff.supply_detect_enable | (state_ff == SMHLC_SAMPLE);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      heavy_ff <= 1'b0;
    end else begin
      heavy_ff <= heavy;
    end
  end

  // The standard variant keeps its regulator source whatever the mode
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dbl_sel_ff <= 1'b0;
    end else begin
      dbl_sel_ff <= LOW_VOLTAGE_VARIANT & heavy;
    end
  end

  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign hrdata = hrdata_ff;
  assign supply_monitor_enable = mon_en_ff;
  assign heavy_load_active = heavy_ff;
  assign lcd_doubled_supply_select = dbl_sel_ff;
  assign irq = irq_ff;

endmodule : smhlc_top
`default_nettype wire

// ===== tb/smhlc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module smhlc_top_asserts
  import smhlc_pkg::*;
#(
  parameter bit LOW_VOLTAGE_VARIANT = 1'b1,
  parameter int unsigned PRESC_CYC = TICK_CYC
) (
  // Clock, reset and bus
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Monitor and power
  input wire logic supply_monitor_enable,
  input wire logic heavy_load_active,
  input wire logic lcd_doubled_supply_select,
  input wire logic irq
);
  // ==========================================
  // Helpers
  int unsigned hi_cnt_ff;
  int unsigned lo_cnt_ff;
  logic [2:0] recent_ff;
  logic wr_dp_ff;
  // Recent cause window: a write landing or the monitor running
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hi_cnt_ff <= 0;
      lo_cnt_ff <= 0;
      recent_ff <= 3'h0;
      wr_dp_ff <= 1'b0;
    end else begin
      hi_cnt_ff <= supply_monitor_enable ? hi_cnt_ff + 1 : 0;
      lo_cnt_ff <= (heavy_load_active && !supply_monitor_enable) ? lo_cnt_ff + 1 : 0;
      wr_dp_ff <= hsel && hready && htrans[1] && hwrite;
      recent_ff <= (wr_dp_ff || supply_monitor_enable) ? 3'h4 : recent_ff - 3'(recent_ff != 3'h0);
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // Properties
  property p_ready; $past(reset_n) |-> hreadyout && !hresp; endproperty
  a_ready: assert property (p_ready) else $error("bus not ready or error response");
  property p_regsrc; lcd_doubled_supply_select == (LOW_VOLTAGE_VARIANT && heavy_load_active); endproperty
  a_regsrc: assert property (p_regsrc) else $error("regulator source wrong");
  property p_len;
    $fell(supply_monitor_enable) && $past(heavy_load_active, 2) |->
      hi_cnt_ff >= SAMPLE_CYC - 1 && hi_cnt_ff <= SAMPLE_CYC + 1;
  endproperty
  a_len: assert property (p_len) else $error("sample length wrong");
  property p_maxlen; supply_monitor_enable && heavy_load_active |-> hi_cnt_ff <= SAMPLE_CYC + 1; endproperty
  a_maxlen: assert property (p_maxlen) else $error("sample too long");
  property p_tick; heavy_load_active |-> lo_cnt_ff <= PRESC_CYC; endproperty
  a_tick: assert property (p_tick) else $error("no sample within a tick period");
  property p_start; $rose(supply_monitor_enable) |-> heavy_load_active || recent_ff != 3'h0; endproperty
  a_start: assert property (p_start) else $error("monitor started without cause");
  property p_mode; $changed(heavy_load_active) |-> recent_ff != 3'h0; endproperty
  a_mode: assert property (p_mode) else $error("mode changed without cause");
  property p_irq; $rose(irq) |-> recent_ff != 3'h0; endproperty
  a_irq: assert property (p_irq) else $error("interrupt without event");
  c_auto: cover property ($fell(supply_monitor_enable) && heavy_load_active);
  c_irq: cover property ($rose(irq));
  c_leave: cover property ($fell(heavy_load_active));
endmodule : smhlc_top_asserts
bind smhlc_top smhlc_top_asserts #(.LOW_VOLTAGE_VARIANT(LOW_VOLTAGE_VARIANT), .PRESC_CYC(PRESC_CYC)) u_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .supply_monitor_enable(supply_monitor_enable),
  .heavy_load_active(heavy_load_active), .lcd_doubled_supply_select(lcd_doubled_supply_select), .irq(irq));
`default_nettype wire

// ===== tb/test_supply_monitor_heavy_load_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_supply_monitor_heavy_load_ctrl;
  import smhlc_pkg::*;
  // Short tick period keeps the run small; must exceed the sample length
  localparam int unsigned PC = 3000;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] e;} smhlc_row_t;
  logic clk_sys, reset_n, hsel, hwrite, hreadyout, hresp, supply_low_raw, sme, hla, lcd, irq;
  logic hla_s, lcd_s;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, q;
  int fails, samples_checked;
  int unsigned n1, n2;
  smhlc_row_t rows [5] = '{
    '{CTRL_ADDR, 32'h0000_0008, 32'h0000_0008},
    '{CTRL_ADDR, 32'h0000_0006, 32'h0000_0000},
    '{IRQ_EN_ADDR, 32'h0000_0007, 32'h0000_0007},
    '{12'h0100, 32'hffff_ffff, 32'h0000_0000},
    '{IRQ_CLR_ADDR, 32'h0000_0007, 32'h0000_0000}};
  smhlc_top #(.LOW_VOLTAGE_VARIANT(1'b1), .PRESC_CYC(PC)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .supply_low_raw(supply_low_raw), .supply_monitor_enable(sme),
    .heavy_load_active(hla), .lcd_doubled_supply_select(lcd), .irq(irq));
  // Standard variant on the same bus: only its mode outputs are watched
  smhlc_top #(.LOW_VOLTAGE_VARIANT(1'b0), .PRESC_CYC(PC)) dut_std (
    .clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(), .hresp(), .hrdata(),
    .supply_low_raw(supply_low_raw), .supply_monitor_enable(), .heavy_load_active(hla_s),
    .lcd_doubled_supply_select(lcd_s), .irq());
  // ==========================================
  // Tasks
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // One single transfer; read data lands in q
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 20);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 40);
    q = hrdata;
    if (n >= 20) begin
      fails++;
      test_done();
    end
  endtask : bus
  task automatic wait_en(input logic v, output int unsigned n);
    n = 0;
    while (sme !== v && n < 4 * PC) begin @(negedge clk_sys); n++; end
    if (n >= 4 * PC) begin
      fails++;
      test_done();
    end
  endtask : wait_en
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // ==========================================
  // Sequence
  initial begin
    {reset_n, hsel, hwrite, supply_low_raw, haddr, htrans, hwdata} = '0;
    fails = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk_sys);
    chk(32'({hreadyout, irq, hla, sme}), 32'h0000_0000);
    reset_n <= 1'b1;
    bus(CTRL_ADDR, 1'b0, 0); chk(q, 32'(CTRL_RESET));
    bus(IRQ_STAT_ADDR, 1'b0, 0); chk(q, 32'(IRQ_RESET));
    foreach (rows[i]) begin
      bus(rows[i].a, 1'b1, rows[i].d);
      bus(rows[i].a, 1'b0, 0); chk(q, rows[i].e);
    end
    // One-shot low detection, only outside heavy mode
    supply_low_raw <= 1'b1;
    bus(CTRL_ADDR, 1'b1, 32'h0000_0001);
    repeat (2010) @(posedge clk_sys);
    bus(CTRL_ADDR, 1'b1, 32'h0000_0000);
    bus(CTRL_ADDR, 1'b0, 0); chk(q, 32'h0000_0002);
    @(negedge clk_sys); chk(32'({hla, lcd}), 32'h0000_0003);
    chk(32'({hla_s, lcd_s}), 32'h0000_0000);
    bus(IRQ_STAT_ADDR, 1'b0, 0); chk(q, 32'h0000_0007);
    chk(32'(irq), 32'h0000_0001);
    bus(IRQ_EN_ADDR, 1'b1, 32'h0000_0000);
    repeat (2) @(negedge clk_sys); chk(32'(irq), 32'h0000_0000);
    bus(IRQ_EN_ADDR, 1'b1, 32'h0000_0007);
    bus(IRQ_CLR_ADDR, 1'b1, 32'h0000_0007);
    repeat (2) @(negedge clk_sys); chk(32'(irq), 32'h0000_0000);
    bus(IRQ_STAT_ADDR, 1'b0, 0); chk(q, 32'h0000_0000);
    // Automatic heavy mode keeps sampling on the tick
    wait_en(1'b1, n1);
    wait_en(1'b0, n1); chk(32'(n1 + 1 >= SAMPLE_CYC && n1 <= SAMPLE_CYC + 1), 32'h0000_0001);
    wait_en(1'b1, n2); chk(n1 + n2, PC);
    @(posedge clk_sys);
    supply_low_raw <= 1'b0;
    bus(CTRL_ADDR, 1'b0, 0); chk(q, 32'h0000_0002);
    wait_en(1'b0, n1);
    repeat (3) @(negedge clk_sys); chk(32'(hla), 32'h0000_0000);
    bus(CTRL_ADDR, 1'b0, 0); chk(q, 32'h0000_0000);
    // Software heavy mode
    @(posedge clk_sys);
    supply_low_raw <= 1'b1;
    bus(CTRL_ADDR, 1'b1, 32'h0000_0008);
    wait_en(1'b1, n1);
    wait_en(1'b0, n1);
    bus(CTRL_ADDR, 1'b0, 0); chk(q, 32'h0000_000a);
    @(posedge clk_sys);
    supply_low_raw <= 1'b0;
    wait_en(1'b1, n1);
    wait_en(1'b0, n1);
    bus(CTRL_ADDR, 1'b0, 0); chk(q, 32'h0000_0008);
    chk(32'(hla), 32'h0000_0001);
    chk(32'({hla_s, lcd_s}), 32'h0000_0002);
    bus(CTRL_ADDR, 1'b1, 32'h0000_0000);
    repeat (3) @(negedge clk_sys); chk(32'(hla), 32'h0000_0000);
    // Mid-run reset clears the mode, the interrupt and the bus
    bus(CTRL_ADDR, 1'b1, 32'h0000_0008);
    repeat (3) @(negedge clk_sys); chk(32'(hla), 32'h0000_0001);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(negedge clk_sys); chk(32'({hreadyout, irq, hla, lcd, sme}), 32'h0000_0000);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    bus(CTRL_ADDR, 1'b0, 32'h0000_0000); chk(q, 32'(CTRL_RESET));
    bus(IRQ_EN_ADDR, 1'b0, 32'h0000_0000); chk(q, 32'(IRQ_RESET));
    test_done();
  end
endmodule : test_supply_monitor_heavy_load_ctrl
`default_nettype wire
